/* logic/cbg_consts.vh */
`ifndef CBG_CONSTS_VH
`define CBG_CONSTS_VH

// clocking
`define CBG_CLK_MHZ 125
`define CBG_XTAL_MHZ 24
`define CBG_INSN_MHZ 12
`define CBG_INSN_DIV (`CBG_XTAL_MHZ / `CBG_INSN_MHZ)

// memory map, decoded on the two top address bits
`define CBG_BLK_HI 19
`define CBG_BLK_LO 18
`define CBG_BLK_BOOT 2'h3
`define CBG_BLK_DATA 2'h2
`define CBG_BOOT_BASE 20'hc0000
`define CBG_DATA_BASE 20'h80000
`define CBG_RAM_TOP 20'h7ffff
`define CBG_BATT_TOP 20'h3ffff

// peripheral select 0 strobe numbers, taken from address bits 4..1
`define CBG_IO_SEL_HI 4
`define CBG_IO_SEL_LO 1
`define CBG_IO_CLOCK 4'h0
`define CBG_IO_KEYPAD 4'h1
`define CBG_IO_KEYBOARD 4'h2
`define CBG_IO_KNOB 4'h3
`define CBG_IO_STATUS 4'h4
`define CBG_IO_PRINTER 4'h5

// peripheral select 1 sub-decode, address bits 2..1
`define CBG_P1_DISK 2'h0
`define CBG_P1_GPIB 2'h1
`define CBG_P1_DACK0 2'h2
`define CBG_P1_DACK1 2'h3

// keyboard frame
`define CBG_KB_STAGES 9
`define CBG_KB_DATA_BITS 8

// keypad
`define CBG_KP_LINES 8
`define CBG_KP_IDLE_COLS 8'hff
`define CBG_KP_NO_KEY 8'h00
`define CBG_KP_SCAN_US 1000
`define CBG_KP_COL_US 10
`define CBG_KP_SCAN_CYC (`CBG_KP_SCAN_US * `CBG_CLK_MHZ)
`define CBG_KP_COL_CYC (`CBG_KP_COL_US * `CBG_CLK_MHZ)

// interrupt code shown when nothing is pending
`define CBG_IRQ_NONE 4'hf

`endif

/* logic/cbg_kbd_rx.v */
`timescale 1ns/1ps
`include "cbg_consts.vh"

module cbg_kbd_rx (
	input wire clk_sys,
	input wire resetn,
	input wire kb_clk,
	input wire kb_data,
	input wire rd_clear,
	output reg [7:0] kb_byte,
	output reg kb_full
);
	reg [1:0] clk_sync;
	reg [1:0] dat_sync;
	reg clk_last;
	reg [`CBG_KB_STAGES-1:0] shift;
	wire fall;

	assign fall = clk_last & ~clk_sync[1];

	always @(posedge clk_sys) begin
		if (!resetn) begin
			clk_sync <= 2'h3;
			dat_sync <= 2'h3;
			clk_last <= 1'b1;
		end else begin
			clk_sync <= {clk_sync[0], kb_clk};
			dat_sync <= {dat_sync[0], kb_data};
			clk_last <= clk_sync[1];
		end
	end

	// bits enter at the top; the start bit arrives first, so it lands in stage 0 last
	always @(posedge clk_sys) begin
		if (!resetn) begin
			shift <= {`CBG_KB_STAGES{1'b0}};
			kb_byte <= 8'h00;
			kb_full <= 1'b0;
		end else begin
			if (shift[0]) begin
				kb_byte <= shift[`CBG_KB_STAGES-1:1];
				shift <= {`CBG_KB_STAGES{1'b0}};
			end else if (rd_clear) begin
				shift <= {`CBG_KB_STAGES{1'b0}};
			end else if (fall) begin
				shift <= {dat_sync[1], shift[`CBG_KB_STAGES-1:1]};
			end
			// a new frame landing with the read wins over the clear
			if (shift[0])
				kb_full <= 1'b1;
			else if (rd_clear)
				kb_full <= 1'b0;
		end
	end
endmodule // cbg_kbd_rx

/* logic/cbg_glue.v */
// Functional notes
// - instruction clock enable runs at half the oscillator rate, 12 from 24 MHz; here it toggles on every 125 MHz clk_sys cycle.
// - capture the 20-bit address from the muxed lines at each cycle start.
// - data buffers enabled only during data phase, pointing the transfer direction.
// - memory space split into four 256k blocks, byte lanes; separate I/O space.
// - C0000-FFFFF selects the boot ROM pair.
// - 80000-BFFFF selects the data ROM pair.
// - 00000-7FFFF selects RAM; battery part write-protected during power fail.
// - peripheral select 0 decoded into sixteen I/O strobes.
// - select 1 gives disk, GPIB, DMA acks; select 2 UART; select 3 video.
// - any video access asserts the async ready line to hold the processor.
// - video ready low deasserts the async ready line, releasing the processor.
// - peripheral interrupts merge into one prioritized request line.
// - lowest-numbered pending request code is readable through a status input port.
// - UART interrupt bypasses the encoder and goes straight to the processor.
// - keypad is eight column strobes by eight row sense inputs.
// - idle: all columns high, rows sampled periodically; zero means no key.
// - nonzero rows: strobe columns one at a time and read rows for each.
// - keyboard shift register cleared when the processor reads the byte.
// - start bit in ninth stage latches eight data bits and raises an interrupt.
// - every knob transition is registered and raises an interrupt.
`timescale 1ns/1ps
`include "cbg_consts.vh"

module cbg_glue #(
	parameter N_EXT_IRQ = 6,
	parameter KP_SCAN_CYC = `CBG_KP_SCAN_CYC
) (
	input wire clk_sys,
	input wire resetn,
	output reg insn_clk_en,
	input wire cpu_ale,
	input wire cpu_rd_n,
	input wire cpu_wr_n,
	input wire cpu_bhe_n,
	input wire cpu_io_cycle,
	input wire [3:0] addr_hi_in,
	input wire [15:0] muxed_addr_data_in,
	output reg [15:0] muxed_addr_data_out,
	output reg muxed_addr_data_oe,
	input wire periph_select_0_n,
	input wire periph_select_1_n,
	input wire periph_select_2_n,
	input wire periph_select_3_n,
	output reg [19:0] latched_address,
	output wire data_buf_en,
	output wire data_buf_to_cpu,
	output wire byte_lo_en_n,
	output wire byte_hi_en_n,
	output wire boot_rom_cs_n,
	output wire data_rom_cs_n,
	output wire ram_cs_n,
	output wire ram_we_n,
	input wire power_fail,
	output wire [15:0] io_strobe_n,
	output wire disk_cs_n,
	output wire gpib_cs_n,
	output wire dma_ack0_n,
	output wire dma_ack1_n,
	output wire uart_cs_n,
	output wire video_cs_n,
	input wire video_rdy_n,
	output wire async_ready_line,
	input wire [N_EXT_IRQ-1:0] periph_irq,
	input wire uart_irq,
	output reg uart_int_req,
	output reg cpu_int_req,
	output reg [3:0] irq_code,
	output reg [7:0] keypad_cols,
	input wire [7:0] keypad_rows,
	input wire kb_clk,
	input wire kb_data,
	input wire knob_a,
	input wire knob_b
);
	localparam N_IRQ = N_EXT_IRQ + 2;
	localparam KP_COL_CYC = `CBG_KP_COL_CYC;
	localparam KP_IDLE = 2'h0;
	localparam KP_STROBE = 2'h1;
	localparam KP_SAMPLE = 2'h2;
	// bus cycle tracking
	reg in_cycle;
	reg strobe_seen;
	reg io_cycle;
	reg rd_last;
	wire rd_act;
	wire wr_act;
	wire data_phase;
	wire rd_end;
	assign rd_act = ~cpu_rd_n;
	assign wr_act = ~cpu_wr_n;
	assign data_phase = in_cycle & (rd_act | wr_act);
	assign rd_end = rd_last & ~rd_act & in_cycle;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			insn_clk_en <= 1'b0;
		end else begin
			insn_clk_en <= ~insn_clk_en;
		end
	end
	always @(posedge clk_sys) begin
		if (!resetn) begin
			latched_address <= 20'h00000;
			in_cycle <= 1'b0;
			strobe_seen <= 1'b0;
			io_cycle <= 1'b0;
			rd_last <= 1'b0;
		end else begin
			rd_last <= rd_act;
			if (cpu_ale) begin
				latched_address <= {addr_hi_in, muxed_addr_data_in};
				io_cycle <= cpu_io_cycle;
				in_cycle <= 1'b1;
				strobe_seen <= 1'b0;
			end else if (in_cycle) begin
				if (rd_act | wr_act)
					strobe_seen <= 1'b1;
				else if (strobe_seen)
					in_cycle <= 1'b0;
			end
		end
	end
	// data buffers and byte lanes
	assign data_buf_en = data_phase;
	assign data_buf_to_cpu = rd_act;
	assign byte_lo_en_n = ~(data_phase & ~latched_address[0]);
	assign byte_hi_en_n = ~(data_phase & ~cpu_bhe_n);
	// memory decode
	wire mem_cycle;
	wire [1:0] blk;
	wire boot_hit;
	wire data_hit;
	wire ram_hit;
	wire batt_hit;
	reg [1:0] pf_sync;
	assign mem_cycle = in_cycle & ~io_cycle;
	assign blk = latched_address[`CBG_BLK_HI:`CBG_BLK_LO];
	assign boot_hit = (blk == `CBG_BLK_BOOT);
	assign data_hit = (blk == `CBG_BLK_DATA);
	assign ram_hit = ~latched_address[`CBG_BLK_HI];
	assign batt_hit = (latched_address <= `CBG_BATT_TOP);
	assign boot_rom_cs_n = ~(mem_cycle & boot_hit);
	assign data_rom_cs_n = ~(mem_cycle & data_hit);
	assign ram_cs_n = ~(mem_cycle & ram_hit);
	// the battery half must not be corrupted while the supply collapses
	assign ram_we_n = ~(mem_cycle & ram_hit & wr_act & ~(batt_hit & pf_sync[1]));
	always @(posedge clk_sys) begin
		if (!resetn)
			pf_sync <= 2'h0;
		else
			pf_sync <= {pf_sync[0], power_fail};
	end
	// peripheral decode
	wire p0;
	wire p1;
	wire [3:0] io_sel;
	wire [1:0] p1_sel;
	genvar gi;
	assign p0 = data_phase & ~periph_select_0_n;
	assign p1 = data_phase & ~periph_select_1_n;
	assign io_sel = latched_address[`CBG_IO_SEL_HI:`CBG_IO_SEL_LO];
	assign p1_sel = latched_address[2:1];
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_io
			assign io_strobe_n[gi] = ~(p0 & (io_sel == gi));
		end
	endgenerate
	assign disk_cs_n = ~(p1 & (p1_sel == `CBG_P1_DISK));
	assign gpib_cs_n = ~(p1 & (p1_sel == `CBG_P1_GPIB));
	assign dma_ack0_n = ~(p1 & (p1_sel == `CBG_P1_DACK0));
	assign dma_ack1_n = ~(p1 & (p1_sel == `CBG_P1_DACK1));
	assign uart_cs_n = ~(in_cycle & ~periph_select_2_n);
	assign video_cs_n = ~(in_cycle & ~periph_select_3_n);
	// video wait: hold until the controller answers, then stay released to cycle end
	reg [1:0] vrdy_sync;
	reg vid_released;
	wire vid_access;
	assign vid_access = in_cycle & ~periph_select_3_n;
	assign async_ready_line = vid_access & ~vid_released;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			vrdy_sync <= 2'h3;
			vid_released <= 1'b0;
		end else begin
			vrdy_sync <= {vrdy_sync[0], video_rdy_n};
			if (!in_cycle || cpu_ale)
				vid_released <= 1'b0;
			else if (vid_access && !vrdy_sync[1])
				vid_released <= 1'b1;
		end
	end
	// knob: any edge on either phase is latched and flagged
	reg [1:0] ka_sync;
	reg [1:0] kb_sync;
	reg [1:0] knob_val;
	reg knob_flag;
	wire knob_rd;
	wire knob_change;
	assign knob_rd = rd_end & ~periph_select_0_n & (io_sel == `CBG_IO_KNOB);
	assign knob_change = ({kb_sync[1], ka_sync[1]} != knob_val);
	always @(posedge clk_sys) begin
		if (!resetn) begin
			ka_sync <= 2'h0;
			kb_sync <= 2'h0;
			knob_val <= 2'h0;
			knob_flag <= 1'b0;
		end else begin
			ka_sync <= {ka_sync[0], knob_a};
			kb_sync <= {kb_sync[0], knob_b};
			knob_val <= {kb_sync[1], ka_sync[1]};
			if (knob_change)
				knob_flag <= 1'b1;
			else if (knob_rd)
				knob_flag <= 1'b0;
		end
	end
	// keyboard receiver
	wire kbd_rd;
	wire [7:0] kb_byte;
	wire kb_full;
	assign kbd_rd = rd_end & ~periph_select_0_n & (io_sel == `CBG_IO_KEYBOARD);
	// XT-style framing only: start bit high, no parity, no stop bit
	cbg_kbd_rx u_kbd (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.kb_clk(kb_clk),
		.kb_data(kb_data),
		.rd_clear(kbd_rd),
		.kb_byte(kb_byte),
		.kb_full(kb_full)
	);

	// keypad scanner
	reg [1:0] kp_state;
	reg [31:0] kp_cnt;
	reg [2:0] kp_col;
	reg [7:0] row_meta;
	reg [7:0] row_s;
	reg [7:0] key_code;
	reg key_flag;
	reg [2:0] row_idx;
	integer ri;
	wire kp_rd;
	assign kp_rd = rd_end & ~periph_select_0_n & (io_sel == `CBG_IO_KEYPAD);
	always @* begin
		row_idx = 3'h0;
		for (ri = `CBG_KP_LINES - 1; ri >= 0; ri = ri - 1)
			if (row_s[ri])
				row_idx = ri[2:0];
	end
	always @(posedge clk_sys) begin
		if (!resetn) begin
			row_meta <= 8'h00;
			row_s <= 8'h00;
		end else begin
			row_meta <= keypad_rows;
			row_s <= row_meta;
		end
	end
	always @(posedge clk_sys) begin
		if (!resetn) begin
			kp_state <= KP_IDLE;
			kp_cnt <= 32'h00000000;
			kp_col <= 3'h0;
			keypad_cols <= `CBG_KP_IDLE_COLS;
			key_code <= 8'h00;
			key_flag <= 1'b0;
		end else begin
			if (kp_rd)
				key_flag <= 1'b0;
			case (kp_state)
			KP_IDLE: begin
				keypad_cols <= `CBG_KP_IDLE_COLS;
				if (kp_cnt >= KP_SCAN_CYC - 1) begin
					kp_cnt <= 32'h00000000;
					if (row_s != `CBG_KP_NO_KEY) begin
						kp_col <= 3'h0;
						kp_state <= KP_STROBE;
					end
				end else begin
					kp_cnt <= kp_cnt + 32'h00000001;
				end
			end
			KP_STROBE: begin
				keypad_cols <= 8'h01 << kp_col;
				kp_cnt <= 32'h00000000;
				kp_state <= KP_SAMPLE;
			end
			KP_SAMPLE: begin
				// rows must settle through the diodes and the synchroniser first
				if (kp_cnt >= KP_COL_CYC - 1) begin
					kp_cnt <= 32'h00000000;
					if (row_s != `CBG_KP_NO_KEY) begin
						key_code <= {2'h0, kp_col, row_idx};
						key_flag <= 1'b1;
					end
					if (kp_col == 3'h7) begin
						kp_state <= KP_IDLE;
						keypad_cols <= `CBG_KP_IDLE_COLS;
					end else begin
						kp_col <= kp_col + 3'h1;
						kp_state <= KP_STROBE;
					end
				end else begin
					kp_cnt <= kp_cnt + 32'h00000001;
				end
			end
			default: kp_state <= KP_IDLE;
			endcase
		end
	end
	// interrupt merge; lowest index wins
	reg [N_EXT_IRQ-1:0] irq_meta;
	reg [N_EXT_IRQ-1:0] irq_s;
	reg [1:0] uart_sync;
	reg [3:0] next_irq_code;
	wire [N_IRQ-1:0] irq_all;
	integer ii;
	assign irq_all = {irq_s, knob_flag, kb_full};
	always @* begin
		next_irq_code = `CBG_IRQ_NONE;
		for (ii = N_IRQ - 1; ii >= 0; ii = ii - 1)
			if (irq_all[ii])
				next_irq_code = ii[3:0];
	end
	always @(posedge clk_sys) begin
		if (!resetn) begin
			irq_meta <= {N_EXT_IRQ{1'b0}};
			irq_s <= {N_EXT_IRQ{1'b0}};
			uart_sync <= 2'h0;
			uart_int_req <= 1'b0;
			cpu_int_req <= 1'b0;
			irq_code <= `CBG_IRQ_NONE;
		end else begin
			irq_meta <= periph_irq;
			irq_s <= irq_meta;
			uart_sync <= {uart_sync[0], uart_irq};
			uart_int_req <= uart_sync[1];
			cpu_int_req <= |irq_all;
			irq_code <= next_irq_code;
		end
	end
	// read-back of the ports this block owns
	wire own_rd;
	assign own_rd = in_cycle & rd_act & ~periph_select_0_n &
		((io_sel == `CBG_IO_KEYPAD) | (io_sel == `CBG_IO_KEYBOARD) |
		(io_sel == `CBG_IO_KNOB) | (io_sel == `CBG_IO_STATUS));
	always @(posedge clk_sys) begin
		if (!resetn) begin
			muxed_addr_data_out <= 16'h0000;
			muxed_addr_data_oe <= 1'b0;
		end else begin
			muxed_addr_data_oe <= own_rd;
			case (io_sel)
			`CBG_IO_KEYPAD: muxed_addr_data_out <= {7'h00, key_flag, key_code};
			`CBG_IO_KEYBOARD: muxed_addr_data_out <= {7'h00, kb_full, kb_byte};
			`CBG_IO_KNOB: muxed_addr_data_out <= {13'h0000, knob_flag, knob_val};
			`CBG_IO_STATUS: muxed_addr_data_out <= {11'h000, cpu_int_req, irq_code};
			default: muxed_addr_data_out <= 16'h0000;
			endcase
		end
	end
endmodule // cbg_glue

/* dv/cbg_monitor.sv */
`timescale 1ns/1ps
module cbg_monitor (
	input wire clk_sys,
	input wire resetn,
	input wire insn_clk_en,
	input wire cpu_ale,
	input wire cpu_rd_n,
	input wire cpu_wr_n,
	input wire [3:0] addr_hi_in,
	input wire [15:0] muxed_addr_data_in,
	input wire [19:0] latched_address,
	input wire data_buf_en,
	input wire data_buf_to_cpu,
	input wire boot_rom_cs_n,
	input wire data_rom_cs_n,
	input wire ram_cs_n,
	input wire periph_select_0_n,
	input wire [15:0] io_strobe_n,
	input wire video_cs_n,
	input wire video_rdy_n,
	input wire async_ready_line,
	input wire uart_irq,
	input wire uart_int_req,
	input wire cpu_int_req,
	input wire [3:0] irq_code,
	input wire [7:0] keypad_cols
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence vid_ack_s;
		!video_cs_n && $fell(video_rdy_n);
	endsequence
	// two sync stages plus the output register
	sequence vid_free_s;
		##[2:4] !async_ready_line;
	endsequence
	insn_half_a: assert property ($past(resetn) |-> insn_clk_en != $past(insn_clk_en))
		else $error("instruction enable not at half rate");
	addr_latch_a: assert property (cpu_ale |=>
		latched_address == $past({addr_hi_in, muxed_addr_data_in}))
		else $error("address not captured");
	buf_dir_a: assert property (data_buf_en |->
		!(cpu_rd_n && cpu_wr_n) && data_buf_to_cpu == !cpu_rd_n)
		else $error("data buffer outside data phase or wrong way");
	boot_map_a: assert property (!boot_rom_cs_n |-> latched_address[19:18] == 2'h3)
		else $error("boot select outside its block");
	data_map_a: assert property (!data_rom_cs_n |-> latched_address[19:18] == 2'h2)
		else $error("data rom select outside its block");
	ram_map_a: assert property (!ram_cs_n |-> !latched_address[19])
		else $error("ram select outside its range");
	one_sel_a: assert property ($onehot0(~{boot_rom_cs_n, data_rom_cs_n, ram_cs_n}))
		else $error("two memory selects at once");
	strobe_dec_a: assert property (io_strobe_n != 16'hffff |-> !periph_select_0_n &&
		!(cpu_rd_n && cpu_wr_n) && io_strobe_n == ~(16'h1 << latched_address[4:1]))
		else $error("io strobe decode wrong");
	vid_hold_a: assert property ($fell(video_cs_n) && video_rdy_n |-> async_ready_line)
		else $error("video access did not hold the processor");
	vid_release_a: assert property (vid_ack_s |-> vid_free_s)
		else $error("video acknowledge did not release the processor");
	irq_req_a: assert property (irq_code != 4'hf |-> cpu_int_req)
		else $error("pending code without request");
	uart_direct_a: assert property ($rose(uart_irq) |-> ##[2:4] uart_int_req)
		else $error("uart request not passed straight on");
	cols_shape_a: assert property (keypad_cols == 8'hff || $onehot(keypad_cols))
		else $error("column strobes neither idle nor single");
endmodule // cbg_monitor

bind cbg_glue cbg_monitor cbg_monitor_inst (.*);

/* dv/cbg_cpu_model.sv */
`timescale 1ns/1ps
module cbg_cpu_model (
	input wire clk_sys,
	input wire async_ready_line,
	input wire [15:0] muxed_addr_data_out,
	output logic cpu_ale,
	output logic cpu_rd_n,
	output logic cpu_wr_n,
	output logic cpu_bhe_n,
	output logic cpu_io_cycle,
	output logic [3:0] addr_hi_in,
	output logic [15:0] muxed_addr_data_in,
	output logic [3:0] pcs_n
);
	initial begin
		{cpu_ale, cpu_rd_n, cpu_wr_n, cpu_bhe_n, cpu_io_cycle} = 5'b01110;
		{addr_hi_in, muxed_addr_data_in, pcs_n} = 24'h00000f;
	end
	// ready high means wait; the strobe stays down until it is seen low
	task automatic cycle(input logic [19:0] a, input logic io, input logic [3:0] sel_n,
		input logic wr, output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge clk_sys);
		cpu_ale <= 1'b1;
		cpu_io_cycle <= io;
		cpu_bhe_n <= 1'b0;
		{addr_hi_in, muxed_addr_data_in} <= a;
		pcs_n <= sel_n;
		@(posedge clk_sys);
		cpu_ale <= 1'b0;
		// while the strobe is down a released line shows the inverse, not the stale address
		muxed_addr_data_in <= wr ? 16'h5a3c : ~a[15:0];
		@(posedge clk_sys);
		cpu_wr_n <= !wr;
		cpu_rd_n <= wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((n < 3 || async_ready_line) && n < 200);
		ok = n < 200;
		rd = muxed_addr_data_out;
		{cpu_rd_n, cpu_wr_n} <= 2'b11;
		@(posedge clk_sys);
		pcs_n <= 4'hf;
		cpu_bhe_n <= 1'b1;
		muxed_addr_data_in <= ~muxed_addr_data_in;
		@(posedge clk_sys);
	endtask
endmodule // cbg_cpu_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic power_fail = 1'b0;
	logic video_rdy_n = 1'b1;
	logic uart_irq = 1'b0;
	logic kb_clk = 1'b1;
	logic kb_data = 1'b1;
	logic knob_a = 1'b0;
	logic knob_b = 1'b0;
	logic key_on = 1'b0;
	logic clr = 1'b0;
	logic [5:0] periph_irq = 6'h00;
	logic [27:0] seen = 28'h0;
	logic [7:0] cols_seen = 8'h00;
	logic [2:0] lane_seen = 3'h0;
	logic [15:0] rd;
	logic ok;
	int errors = 0;
	int cmp_count = 0;
	wire cpu_ale, cpu_rd_n, cpu_wr_n, cpu_bhe_n, cpu_io_cycle, insn_clk_en;
	wire [3:0] addr_hi_in, pcs_n, irq_code;
	wire [15:0] muxed_addr_data_in, muxed_addr_data_out, io_strobe_n;
	wire [19:0] latched_address;
	wire [7:0] keypad_cols, keypad_rows;
	wire muxed_addr_data_oe, data_buf_en, data_buf_to_cpu, byte_lo_en_n, byte_hi_en_n;
	wire boot_rom_cs_n, data_rom_cs_n, ram_cs_n, ram_we_n, disk_cs_n, gpib_cs_n;
	wire dma_ack0_n, dma_ack1_n, uart_cs_n, video_cs_n, async_ready_line, uart_int_req;
	wire cpu_int_req, periph_select_0_n, periph_select_1_n, periph_select_2_n;
	wire periph_select_3_n;
	assign {periph_select_3_n, periph_select_2_n, periph_select_1_n, periph_select_0_n} = pcs_n;
	// one key, column 5 row 2
	assign keypad_rows = (key_on && keypad_cols[5]) ? 8'h04 : 8'h00;
	cbg_glue #(.KP_SCAN_CYC(200)) cbg_glue_inst (.*);
	cbg_cpu_model cbg_cpu_model_inst (.*);
	initial forever #4 clk_sys = ~clk_sys;
	// selects are combinational, so collect them at every edge of a cycle
	always @(posedge clk_sys) begin
		seen <= clr ? 28'h0 : seen | {~io_strobe_n, ~{dma_ack1_n, dma_ack0_n, gpib_cs_n,
			disk_cs_n}, ~uart_cs_n, ~video_cs_n, ~{boot_rom_cs_n, data_rom_cs_n, ram_cs_n},
			~ram_we_n, async_ready_line, data_buf_en};
		cols_seen <= clr ? 8'h00 : cols_seen | (keypad_cols == 8'hff ? 8'h00 : keypad_cols);
		lane_seen <= clr ? 3'h0 : lane_seen | {~byte_hi_en_n, ~byte_lo_en_n, muxed_addr_data_oe};
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic [19:0] a, input logic io, input logic [3:0] s, input logic wr);
		@(posedge clk_sys);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		cbg_cpu_model_inst.cycle(a, io, s, wr, rd, ok);
		chk("bus_done", 1, ok);
	endtask
	task t_mem;
		logic [19:0] adr [6] = '{20'h00000, 20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000, 20'hfffff};
		chk("cs_idle", 19'h7ffff, {boot_rom_cs_n, data_rom_cs_n, ram_cs_n, io_strobe_n});
		chk("idle_state", 12'hfff, {keypad_cols, irq_code});
		for (int i = 0; i < 6; i++) begin
			bus(adr[i], 1'b0, 4'hf, 1'b0);
			chk("mem_sel", (32'h8 << (i / 2)) | 32'h1, seen);
			chk("mem_lanes", {1'b1, ~adr[i][0], 1'b0}, lane_seen);
		end
		power_fail <= 1'b1;
		bus(20'h00010, 1'b0, 4'hf, 1'b1);
		chk("ram_wp", 32'h9, seen);
		bus(20'h40010, 1'b0, 4'hf, 1'b1);
		chk("ram_we", 32'hd, seen);
		power_fail <= 1'b0;
		bus(20'h00010, 1'b0, 4'hf, 1'b1);
		chk("ram_we", 32'hd, seen);
		$display("memory map done");
	endtask
	task t_io;
		for (int n = 0; n < 16; n++) begin
			bus(20'(n * 2), 1'b1, 4'he, 1'b0);
			chk("io_strobe", (32'h1000 << n) | 32'h1, seen);
			chk("io_lanes", {2'b11, n >= 1 && n <= 4}, lane_seen);
		end
		for (int k = 0; k < 4; k++) begin
			bus(20'(k * 2), 1'b1, 4'hd, 1'b0);
			chk("p1_strobe", (32'h100 << k) | 32'h1, seen);
		end
		bus(20'h00000, 1'b1, 4'hb, 1'b0);
		chk("uart_sel", 32'h81, seen);
		fork
			bus(20'h00000, 1'b1, 4'h7, 1'b0);
			begin
				repeat (12) @(posedge clk_sys);
				video_rdy_n <= 1'b0;
			end
		join
		video_rdy_n <= 1'b1;
		chk("video_sel", 32'h43, seen);
		$display("io decode done");
	endtask
	task t_kbd;
		logic [8:0] f;
		for (int j = 0; j < 2; j++) begin
			f = {(j == 0) ? 8'ha5 : 8'h5a, 1'b1};
			for (int i = 0; i < 9; i++) begin
				kb_data <= f[i];
				repeat (5) @(posedge clk_sys);
				kb_clk <= 1'b0;
				repeat (5) @(posedge clk_sys);
				kb_clk <= 1'b1;
			end
			kb_data <= 1'b1;
			repeat (6) @(posedge clk_sys);
			chk("kb_irq", 5'h10, {cpu_int_req, irq_code});
			bus(20'h00004, 1'b1, 4'he, 1'b0);
			chk("kb_byte", {1'b1, f[8:1]}, rd[8:0]);
			repeat (6) @(posedge clk_sys);
			chk("kb_clear", 5'h0f, {cpu_int_req, irq_code});
		end
		$display("keyboard done");
	endtask
	task t_irq;
		knob_a <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("knob_irq", 5'h11, {cpu_int_req, irq_code});
		bus(20'h00006, 1'b1, 4'he, 1'b0);
		chk("knob_val", 3'b101, rd[2:0]);
		knob_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		bus(20'h00006, 1'b1, 4'he, 1'b0);
		chk("knob_val", 3'b111, rd[2:0]);
		periph_irq <= 6'h0a;
		repeat (5) @(posedge clk_sys);
		chk("irq_prio", 5'h13, {cpu_int_req, irq_code});
		bus(20'h00008, 1'b1, 4'he, 1'b0);
		chk("irq_status", 5'h13, rd[4:0]);
		uart_irq <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("uart_irq", 5'h13, {uart_int_req, irq_code});
		periph_irq <= 6'h00;
		uart_irq <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk("irq_none", 6'h0f, {cpu_int_req, uart_int_req, irq_code});
		$display("interrupts done");
	endtask
	task t_keypad;
		int n;
		clr <= 1'b1;
		repeat (2) @(posedge clk_sys);
		clr <= 1'b0;
		repeat (600) @(posedge clk_sys);
		chk("pad_idle", 8'h00, cols_seen);
		key_on <= 1'b1;
		n = 0;
		while (!(cols_seen[5] && keypad_cols === 8'hff) && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		key_on <= 1'b0;
		chk("pad_scan", 6'h3f, cols_seen[5:0]);
		bus(20'h00002, 1'b1, 4'he, 1'b0);
		chk("pad_code", 9'h12a, rd[8:0]);
		$display("keypad done");
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_mem;
		t_io;
		t_kbd;
		t_irq;
		t_keypad;
		report_and_stop;
	end
	// the keypad scan dominates the run at about 10k cycles
	initial begin
		repeat (50000) @(posedge clk_sys);
		errors++;
		report_and_stop;
	end
endmodule // testbench
